//--- design/cs_filter.sv
// How it works
// [R01] ffi code picks 6/10/18/34 burst samples
// [R02] drop max and min, average rest
// [R03] six-bit charge current, zero disables charging
// [R04] three-bit charge time code driven out
// [R05] sfi code picks 4/6/10/18 averaged results
// [R06] sample interval 1 ms doubling to 128
// [R07] one burst per interval feeds stage two
// [R08] filtered output every count times interval
// [R09] front end configuration decoded at 0x5c
// [R10] auto-configured charge time overrides software value
// [R11] new filtered value pulsed to touch logic
// [R12] software keeps both ffi copies matched
// [R13] truncating averages, front end idles between bursts
`include "cs_cfg.svh"

module cs_filter
    import cs_pkg::*;
#(
    parameter int DW           = 10,
    parameter int IVL_BASE_CYC = `CS_INTERVAL_BASE_NS / `CS_CLK_PERIOD_NS
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_we,
    input  wire logic          reg_re,
    output logic [7:0]         reg_rdata,
    input  wire logic          afe_sample_valid,
    input  wire logic [DW-1:0] afe_sample_data,
    input  wire logic          autocfg_time_valid,
    input  wire logic [2:0]    autocfg_time,
    output logic               analog_front_end_run,
    output logic [5:0]         charge_current_select,
    output logic [2:0]         charge_time_select,
    output logic [DW-1:0]      filtered_data,
    output logic               filtered_valid
);

    localparam int SW = 16;
    localparam int AW = 15;

    logic [7:0]    afe_cfg_r;
    logic [7:0]    filt_cfg_r;
    logic [7:0]    reg_rdata_r;
    logic [5:0]    cdc_r;
    logic [2:0]    cdt_r;
    logic [24:0]   ivl_cnt_r;
    logic [24:0]   ivl_limit;
    logic          tick;
    cs_s1_state_t  s1_state_r;
    logic          run_r;
    logic [5:0]    s1_cnt_r;
    logic [5:0]    s1_n_r;
    logic [2:0]    s1_shift_r;
    logic [SW-1:0] s1_sum_r;
    logic [DW-1:0] s1_max_r;
    logic [DW-1:0] s1_min_r;
    logic [SW-1:0] s1_sum_nxt;
    logic [DW-1:0] s1_max_nxt;
    logic [DW-1:0] s1_min_nxt;
    logic [SW-1:0] s1_trim;
    logic          s1_last;
    logic          s1_done_r;
    logic [DW-1:0] s1_result_r;
    logic [AW-1:0] s2_acc_r;
    logic [4:0]    s2_cnt_r;
    logic [4:0]    s2_m_r;
    logic [4:0]    s2_m_cur;
    logic          div_start_r;
    logic [AW-1:0] div_num_r;
    logic [4:0]    div_den_r;
    logic          div_done;
    logic [AW-1:0] div_q;
    logic [DW-1:0] fdata_r;
    logic          fvalid_r;
    logic [4:0]    s1_since_r;

    // burst length per first-stage code
    function automatic logic [5:0] ffi_count(input logic [1:0] code);
        case (code)
            2'h0:    ffi_count = 6'h06;
            2'h1:    ffi_count = 6'h0a;
            2'h2:    ffi_count = 6'h12;
            default: ffi_count = 6'h22;
        endcase
    endfunction : ffi_count

    // averaged result count per second-stage code
    function automatic logic [4:0] sfi_count(input logic [1:0] code);
        case (code)
            2'h0:    sfi_count = 5'h04;
            2'h1:    sfi_count = 5'h06;
            2'h2:    sfi_count = 5'h0a;
            default: sfi_count = 5'h12;
        endcase
    endfunction : sfi_count

    ////////////////////////////////////////////////////////////////////////
    // register file
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            afe_cfg_r  <= `CS_AFE_CFG_RST;
            filt_cfg_r <= `CS_FILT_CFG_RST;
        end else if (reg_we) begin
            if (reg_addr == `CS_AFE_CFG_ADDR) begin // R09
                afe_cfg_r <= reg_wdata;
            end
            if (reg_addr == `CS_FILT_CFG_ADDR) begin
                filt_cfg_r <= reg_wdata;
            end
        end
    end

    // registered read data, unmapped addresses read zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_re) begin
            unique case (reg_addr)
                `CS_AFE_CFG_ADDR:  reg_rdata_r <= afe_cfg_r; // R09
                `CS_FILT_CFG_ADDR: reg_rdata_r <= filt_cfg_r;
                `CS_FDATA_LO_ADDR: reg_rdata_r <= fdata_r[7:0];
                `CS_FDATA_HI_ADDR: reg_rdata_r <= 8'(fdata_r >> 8);
                default:           reg_rdata_r <= 8'h00;
            endcase
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // front end drive; auto-config owns the charge time when it offers one
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cdc_r <= 6'h00;
            cdt_r <= 3'h0;
        end else begin
            cdc_r <= afe_cfg_r[`CS_CDC_MSB:`CS_CDC_LSB]; // R03
            if (autocfg_time_valid) begin
                cdt_r <= autocfg_time; // R10
            end else begin
                cdt_r <= filt_cfg_r[`CS_CDT_MSB:`CS_CDT_LSB]; // R04
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample interval: base period shifted by the interval code
    assign ivl_limit = (25'(IVL_BASE_CYC) << filt_cfg_r[`CS_ESI_MSB:`CS_ESI_LSB])
                       - 25'h0000001; // R06
    assign tick      = ivl_cnt_r >= ivl_limit;

    // >= so that shortening the code mid-period cannot strand the counter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ivl_cnt_r <= '0;
        end else if (tick) begin
            ivl_cnt_r <= '0; // R06
        end else begin
            ivl_cnt_r <= ivl_cnt_r + 25'h0000001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // first stage running sums
    always_comb begin
        s1_sum_nxt = s1_sum_r + SW'(afe_sample_data);
        s1_max_nxt = (afe_sample_data > s1_max_r) ? afe_sample_data : s1_max_r;
        s1_min_nxt = (afe_sample_data < s1_min_r) ? afe_sample_data : s1_min_r;
        s1_trim    = s1_sum_nxt - SW'(s1_max_nxt) - SW'(s1_min_nxt); // R02
    end

    assign s1_last = (s1_state_r == CS_S1_RUN) && afe_sample_valid
                     && (s1_cnt_r == s1_n_r - 6'h01);

    // burst sequencer; remaining count is a power of two so divide is a shift
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_state_r  <= CS_S1_IDLE;
            run_r       <= 1'b0;
            s1_cnt_r    <= 6'h00;
            s1_n_r      <= 6'h06;
            s1_shift_r  <= 3'h2;
            s1_sum_r    <= '0;
            s1_max_r    <= '0;
            s1_min_r    <= '1;
            s1_done_r   <= 1'b0;
            s1_result_r <= '0;
        end else begin
            s1_done_r <= 1'b0;
            unique case (s1_state_r)
                CS_S1_IDLE: begin
                    // no charge current means no burst at all
                    if (tick && (afe_cfg_r[`CS_CDC_MSB:`CS_CDC_LSB] != 6'h00)) begin // R03 R07
                        s1_state_r <= CS_S1_RUN;
                        run_r      <= 1'b1;
                        s1_cnt_r   <= 6'h00;
                        s1_n_r     <= ffi_count(afe_cfg_r[`CS_FFI_MSB:`CS_FFI_LSB]); // R01
                        s1_shift_r <= 3'(afe_cfg_r[`CS_FFI_MSB:`CS_FFI_LSB]) + 3'h2;
                        s1_sum_r   <= '0;
                        s1_max_r   <= '0;
                        s1_min_r   <= '1;
                    end
                end
                CS_S1_RUN: begin
                    if (afe_sample_valid) begin
                        s1_sum_r <= s1_sum_nxt;
                        s1_max_r <= s1_max_nxt;
                        s1_min_r <= s1_min_nxt;
                        s1_cnt_r <= s1_cnt_r + 6'h01;
                    end
                    if (s1_last) begin
                        s1_state_r  <= CS_S1_IDLE;
                        run_r       <= 1'b0; // R13
                        s1_done_r   <= 1'b1; // R07
                        s1_result_r <= DW'(s1_trim >> s1_shift_r); // R02 R13
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // second stage accumulation; count latched at the first result
    assign s2_m_cur = (s2_cnt_r == 5'h00) ? sfi_count(filt_cfg_r[`CS_SFI_MSB:`CS_SFI_LSB])
                                          : s2_m_r; // R05

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s2_acc_r    <= '0;
            s2_cnt_r    <= 5'h00;
            s2_m_r      <= 5'h04;
            div_start_r <= 1'b0;
            div_num_r   <= '0;
            div_den_r   <= 5'h04;
        end else begin
            div_start_r <= 1'b0;
            if (s1_done_r) begin
                s2_m_r <= s2_m_cur;
                if (s2_cnt_r == s2_m_cur - 5'h01) begin
                    div_num_r   <= s2_acc_r + AW'(s1_result_r); // R08
                    div_den_r   <= s2_m_cur;
                    div_start_r <= 1'b1;
                    s2_acc_r    <= '0;
                    s2_cnt_r    <= 5'h00;
                end else begin
                    s2_acc_r <= s2_acc_r + AW'(s1_result_r);
                    s2_cnt_r <= s2_cnt_r + 5'h01;
                end
            end
        end
    end

    // divider quotient truncates, average never exceeds the sample range
    cs_div #(
        .NW (AW),
        .VW (5)
    ) u_div (
        .clock    (clock),
        .rst_n    (rst_n),
        .start    (div_start_r),
        .dividend (div_num_r),
        .divisor  (div_den_r),
        .done     (div_done),
        .quotient (div_q)
    );

    // output word and one-cycle hand-off to touch evaluation
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fdata_r  <= '0;
            fvalid_r <= 1'b0;
        end else begin
            fvalid_r <= div_done; // R11
            if (div_done) begin
                fdata_r <= DW'(div_q); // R13
            end
        end
    end

    // checking aid: first-stage results since the last output
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_since_r <= 5'h00;
        end else if (fvalid_r) begin
            s1_since_r <= {4'h0, s1_done_r};
        end else if (s1_done_r) begin
            s1_since_r <= s1_since_r + 5'h01;
        end
    end

    assign reg_rdata             = reg_rdata_r;
    assign analog_front_end_run  = run_r;
    assign charge_current_select = cdc_r;
    assign charge_time_select    = cdt_r;
    assign filtered_data         = fdata_r;
    assign filtered_valid        = fvalid_r;

    ////////////////////////////////////////////////////////////////////////
    burst_end_a: assert property (@(posedge clock) disable iff (!rst_n) // R01
        s1_last |=> s1_done_r && !run_r)
        else $error("burst did not end on last sample");
    trim_range_a: assert property (@(posedge clock) disable iff (!rst_n) // R02
        s1_done_r |-> (s1_result_r <= s1_max_r) && (s1_result_r >= s1_min_r))
        else $error("first stage average out of sample range");
    no_charge_a: assert property (@(posedge clock) disable iff (!rst_n) // R03
        (s1_state_r == CS_S1_IDLE && afe_cfg_r[5:0] == 6'h00) |=> !run_r)
        else $error("burst started with charging disabled");
    ctime_sw_a: assert property (@(posedge clock) disable iff (!rst_n) // R04
        !autocfg_time_valid |=> charge_time_select == $past(filt_cfg_r[7:5]))
        else $error("charge time not taken from register");
    ctime_auto_a: assert property (@(posedge clock) disable iff (!rst_n) // R10
        autocfg_time_valid |=> charge_time_select == $past(autocfg_time))
        else $error("auto charge time not applied");
    out_count_a: assert property (@(posedge clock) disable iff (!rst_n) // R05
        fvalid_r |-> s1_since_r == s2_m_r)
        else $error("output not after selected result count");
    ivl_wrap_a: assert property (@(posedge clock) disable iff (!rst_n) // R06
        tick |=> ivl_cnt_r == 25'h0000000)
        else $error("interval counter failed to wrap");
    burst_tick_a: assert property (@(posedge clock) disable iff (!rst_n) // R07
        $rose(run_r) |-> $past(tick))
        else $error("burst started off the interval tick");
    result_a: assert property (@(posedge clock) disable iff (!rst_n) // R08
        div_start_r |-> ##17 fvalid_r)
        else $error("filtered value late");
    handoff_a: assert property (@(posedge clock) disable iff (!rst_n) // R11
        div_done |=> fvalid_r && filtered_data == $past(div_q[DW-1:0]))
        else $error("filtered value not handed over");
    afe_read_a: assert property (@(posedge clock) disable iff (!rst_n) // R09
        (reg_re && reg_addr == 8'h5c) |=> reg_rdata == $past(afe_cfg_r))
        else $error("front end configuration read wrong");
    idle_a: assert property (@(posedge clock) disable iff (!rst_n) // R13
        (s1_state_r == CS_S1_IDLE) |-> !run_r)
        else $error("front end running between bursts");

endmodule : cs_filter

//--- design/cs_cfg.svh
`ifndef CS_CFG_SVH
`define CS_CFG_SVH

// register addresses
`define CS_FDATA_LO_ADDR    8'h04
`define CS_FDATA_HI_ADDR    8'h05
`define CS_AFE_CFG_ADDR     8'h5c
`define CS_FILT_CFG_ADDR    8'h5d

// field positions, front end configuration
`define CS_FFI_MSB          7
`define CS_FFI_LSB          6
`define CS_CDC_MSB          5
`define CS_CDC_LSB          0
// field positions, filter configuration
`define CS_CDT_MSB          7
`define CS_CDT_LSB          5
`define CS_SFI_MSB          4
`define CS_SFI_LSB          3
`define CS_ESI_MSB          2
`define CS_ESI_LSB          0

// reset values
`define CS_AFE_CFG_RST      8'h10
`define CS_FILT_CFG_RST     8'h24

// timing
`define CS_CLK_PERIOD_NS    4
`define CS_INTERVAL_BASE_NS 1000000

`endif

//--- design/cs_pkg.sv
package cs_pkg;

    // first stage burst sequencer
    typedef enum logic {CS_S1_IDLE, CS_S1_RUN} cs_s1_state_t;

endpackage : cs_pkg

//--- design/cs_div.sv
// restoring divider, one quotient bit per clock
module cs_div #(
    parameter int NW = 15,
    parameter int VW = 5
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          start,
    input  wire logic [NW-1:0] dividend,
    input  wire logic [VW-1:0] divisor,
    output logic               done,
    output logic [NW-1:0]      quotient
);

    logic [VW-1:0] rem_r;
    logic [VW-1:0] dvs_r;
    logic [NW-1:0] quo_r;
    logic [4:0]    cnt_r;
    logic          busy_r;
    logic          done_r;
    logic [VW:0]   trial;
    logic          fits;

    // trial subtraction of the next dividend bit
    always_comb begin
        trial = {rem_r, quo_r[NW-1]};
        fits  = trial >= {1'b0, dvs_r};
    end

    ////////////////////////////////////////////////////////////////////////
    // iteration; remainder always stays below the divisor so VW bits do
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rem_r  <= '0;
            dvs_r  <= '0;
            quo_r  <= '0;
            cnt_r  <= 5'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (start) begin
                rem_r  <= '0;
                dvs_r  <= divisor;
                quo_r  <= dividend;
                cnt_r  <= 5'h00;
                busy_r <= 1'b1;
            end else if (busy_r) begin
                rem_r <= fits ? VW'(trial - {1'b0, dvs_r}) : VW'(trial);
                quo_r <= {quo_r[NW-2:0], fits};
                cnt_r <= cnt_r + 5'h01;
                if (cnt_r == 5'(NW - 1)) begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
            end
        end
    end

    assign done     = done_r;
    assign quotient = quo_r;

endmodule : cs_div

//--- testbench/cs_afe_model.sv
module cs_afe_model #(
    parameter int DW = 10
) (
    input  wire logic          clock,
    input  wire logic          analog_front_end_run,
    input  wire logic [1:0]    gap,
    output logic               afe_sample_valid,
    output logic [DW-1:0]      afe_sample_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DW-1:0] seq_r;
    logic [1:0]    wait_r;

    initial begin
        afe_sample_valid = 1'b0;
        afe_sample_data  = '0;
        seq_r            = DW'(10'h05a);
        wait_r           = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one conversion per gap+1 cycles, only while the run window is open
    // data flips when not valid so a stale word is never mistaken for a sample
    always @(negedge clock) begin
        if (analog_front_end_run && wait_r == 2'h0) begin
            afe_sample_valid <= 1'b1;
            afe_sample_data  <= seq_r;
            seq_r            <= seq_r + DW'(10'h1d5); // wraps, so max and min move about
            wait_r           <= gap;
        end else begin
            afe_sample_valid <= 1'b0;
            afe_sample_data  <= ~afe_sample_data;
            if (wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule : cs_afe_model

//--- testbench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int IVL = 64;

    logic       clock, rst_n, reg_we, reg_re, afe_sample_valid, filtered_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [9:0] afe_sample_data, filtered_data, last_exp;
    logic       autocfg_time_valid, analog_front_end_run, prev_run, prev_fv;
    logic [2:0] autocfg_time, charge_time_select;
    logic [5:0] charge_current_select;
    logic [1:0] gap;
    int         miscompares, cmp_count, ffi_e, sfi_e, esi_e, n, sum, mx, mn, m, s;
    int         rises, outs, full_cnt, since_rise, since_out;
    int         q[$];

    cs_filter #(.DW(10), .IVL_BASE_CYC(IVL)) i_cs_filter (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .afe_sample_valid(afe_sample_valid), .afe_sample_data(afe_sample_data),
        .autocfg_time_valid(autocfg_time_valid), .autocfg_time(autocfg_time),
        .analog_front_end_run(analog_front_end_run),
        .charge_current_select(charge_current_select),
        .charge_time_select(charge_time_select),
        .filtered_data(filtered_data), .filtered_valid(filtered_valid));

    cs_afe_model #(.DW(10)) i_cs_afe_model (
        .clock(clock), .analog_front_end_run(analog_front_end_run), .gap(gap),
        .afe_sample_valid(afe_sample_valid), .afe_sample_data(afe_sample_data));

    ////////////////////////////////////////////////////////////////////////////////
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr  = a;
        reg_wdata = d;
        reg_we    = 1'b1;
        @(negedge clock);
        reg_we    = 1'b0;
    endtask : reg_write

    // read data stands one cycle after the taking edge, so sample at that negedge
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        reg_re   = 1'b1;
        @(negedge clock);
        reg_re   = 1'b0;
        check(reg_rdata, exp);
    endtask : reg_read

    task automatic do_reset();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
    endtask : do_reset

    task automatic wait_for(input int r, input int o);
        int lim;
        lim = 0;
        while ((rises < r || outs < o) && lim < 40000) begin
            @(negedge clock);
            lim++;
        end
        check(lim < 40000, 1'b1);
    endtask : wait_for

    // fresh reset per setting keeps the output groups aligned with our queue
    task automatic run_cfg(input int f, input int sf, input int e, input int g, input int o);
        do_reset();
        ffi_e = f;
        sfi_e = sf;
        esi_e = e;
        gap   = g[1:0];
        reg_write(8'h5c, {f[1:0], 6'h2a});
        reg_write(8'h5d, {3'h1, sf[1:0], e[2:0]});
        wait_for(3, o);
        if (o > 0) begin
            reg_read(8'h04, last_exp[7:0]);
            reg_read(8'h05, {6'h00, last_exp[9:8]});
        end
    endtask : run_cfg

    function automatic int nsamp(input int f);
        return (4 << f) + 2;
    endfunction : nsamp

    function automatic int mcount(input int sf);
        return (2 << sf) + 2;
    endfunction : mcount

    ////////////////////////////////////////////////////////////////////////////////
    // reference monitor; inputs seen at negedge are the values the last posedge took
    always @(negedge clock) begin
        if (!rst_n) begin
            {n, sum, mx, rises, outs, full_cnt, since_rise, since_out} = '0;
            mn = 1023;
            q.delete();
            prev_run = 1'b0;
            prev_fv  = 1'b0;
        end else begin
            since_rise++;
            since_out++;
            if (afe_sample_valid && prev_run && n < nsamp(ffi_e)) begin
                n++;
                sum += afe_sample_data;
                if (afe_sample_data > mx) mx = afe_sample_data;
                if (afe_sample_data < mn) mn = afe_sample_data;
            end
            // run may stand one edge past the last sample, never two
            if (n == nsamp(ffi_e) && analog_front_end_run) begin
                full_cnt++;
                if (full_cnt == 2) check(analog_front_end_run, 1'b0);
            end
            if (!analog_front_end_run && prev_run) begin
                check(n, nsamp(ffi_e));
                q.push_back((sum - mx - mn) >> (ffi_e + 2));
                {n, sum, mx, full_cnt} = '0;
                mn = 1023;
            end
            if (analog_front_end_run && !prev_run) begin
                rises++;
                if (rises > 2) check(since_rise, IVL << esi_e);
                since_rise = 0;
            end
            if (filtered_valid) begin
                check(prev_fv, 1'b0);
                outs++;
                m = mcount(sfi_e);
                if (outs > 1) check(since_out, m * (IVL << esi_e));
                since_out = 0;
                check(q.size(), m);
                s = 0;
                while (q.size() > 0) s += q.pop_front();
                last_exp = 10'(s / m);
                check(filtered_data, last_exp);
            end
            prev_run = analog_front_end_run;
            prev_fv  = filtered_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog; the longest setting needs about 25k cycles
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        #360000;
        miscompares++;
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {rst_n, reg_we, reg_re, autocfg_time_valid} = '0;
        {reg_addr, reg_wdata, autocfg_time, ffi_e, sfi_e, esi_e} = '0;
        gap = 2'h1;
        do_reset();
        reg_read(8'h5c, 8'h10);
        reg_read(8'h5d, 8'h24);
        check(charge_current_select, 6'h10);
        check(charge_time_select, 3'h1);
        reg_write(8'h33, 8'hff);
        reg_read(8'h33, 8'h00);
        reg_write(8'h04, 8'hff);
        reg_read(8'h04, 8'h00);
        for (int c = 0; c < 8; c++) begin
            reg_write(8'h5d, {c[2:0], 5'h04});
            @(negedge clock);
            check(charge_time_select, c[2:0]);
            reg_read(8'h5d, {c[2:0], 5'h04});
        end
        autocfg_time       = 3'h6;
        autocfg_time_valid = 1'b1;
        repeat (2) @(negedge clock);
        check(charge_time_select, 3'h6);
        autocfg_time_valid = 1'b0;
        reg_write(8'h5c, 8'h3f);
        @(negedge clock);
        check(charge_current_select, 6'h3f);
        // zero current must keep the front end parked through many ticks
        reg_write(8'h5c, 8'h00);
        reg_write(8'h5d, 8'h20);
        repeat (1500) @(negedge clock);
        check(charge_current_select, 6'h00);
        check(rises, 0);
        run_cfg(0, 0, 0, 1, 2);
        run_cfg(1, 1, 1, 2, 2);
        run_cfg(2, 2, 2, 1, 2);
        run_cfg(3, 3, 0, 0, 2);
        run_cfg(0, 0, 7, 2, 0);
        finish_test();
    end
endmodule : tb
